/* verilog/rsbm_defines.vh */
// Constants for the subaddress buffer manager: descriptor layout, control
// word fields, message information word fields and sizes.
// Assumes a 16-bit shared RAM with one-cycle read latency.
`ifndef RSBM_DEFINES_VH
`define RSBM_DEFINES_VH
`define RSBM_ADDR_W 13
`define RSBM_DATA_W 16
`define RSBM_DESC_BASE 13'h0400
`define RSBM_DESC_CTRL 2'h0
`define RSBM_DESC_PTR 2'h1
`define RSBM_DESC_CUR 2'h2
`define RSBM_DESC_END 2'h3
`define RSBM_CW_INDEX_ZERO_IRQ 15
`define RSBM_CW_IWA 14
`define RSBM_CW_IBR 13
`define RSBM_CW_PINGPONG_ENABLE 2
`define RSBM_CW_CIR1 1
`define RSBM_CW_CIR2 0
`define RSBM_MIW_BROADCAST_FLAG 15
`define RSBM_MIW_ERR 14
`define RSBM_MIW_BUSY 13
`define RSBM_MIW_ILL 12
`define RSBM_MESSAGE_INDEX_COUNT_MASK 16'h03ff
`define RSBM_REC_HDR 13'h0002
`endif

/* verilog/rsbm_desc_addr.v */
// Descriptor address generator.
// Assumes a command word of 11 bits: T/R, subaddress and word count field.
`timescale 1ns/100ps
`include "rsbm_defines.vh"
module rsbm_desc_addr
#(
  parameter ADDR_W = 13
)
(
  // Command fields.
  input wire [10:0] cmdFields,
  input wire [1:0] wordSel,
  // Address out.
  output wire [ADDR_W-1:0] descAddr
);
  // Four words per block, one block per T/R, subaddress, count combination.
  assign descAddr = `RSBM_DESC_BASE + {cmdFields[10:0], wordSel};
endmodule

/* verilog/rsbm_ptr_next.v */
// Circular pointer update: advance or wrap to start.
// Assumes pointers are RAM word addresses.
`timescale 1ns/100ps
module rsbm_ptr_next
#(
  parameter ADDR_W = 13
)
(
  // Pointers in.
  input wire [ADDR_W-1:0] lastPlusOne,
  input wire [ADDR_W-1:0] startPtr,
  input wire [ADDR_W-1:0] endPtr,
  // Result.
  output wire [ADDR_W-1:0] nextPtr,
  output wire wrapped
);
  assign wrapped = (lastPlusOne >= endPtr);
  assign nextPtr = wrapped ? startPtr : lastPlusOne;
endmodule

/* verilog/rsbm_top.v */
// Subaddress buffer manager for a remote terminal: indexed mode with
// in-buffer broadcast, and circular mode 1.
// Assumes the message processor gives a command strobe, data word strobes,
// and a done strobe with outcome; RAM answers reads one cycle later.
// Notes on behaviour
// - Broadcast stored in buffer A, flag set
// - Good indexed messages decrement nonzero index, advance pointer unless it reaches zero
// - Broadcast irq needs descriptor and enable bits
// - Good message decrements nonzero index count
// - Nonzero result writes back advanced pointer
// - Zero result keeps pointer, posts irq
// - Circular only for subaddress commands
// - Circular one: pingpong, circ two clear
// - Words: control, start, current, end
// - Only current and pointer words ever written back
// - At or past end wraps to start
// - Descriptor chosen by T/R, subaddress, count
// - Receive data at current plus two
// - Transmit data from current plus two
// - Indexed when all three mode bits zero
// - No decrement if illegal or zero
// - Bad message keeps current pointer
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "rsbm_defines.vh"
module rsbm_top
#(
  parameter ADDR_W = 13,
  parameter DATA_W = 16
)
(
  // Clock and reset.
  input wire sys_clk,
  input wire rst_n,
  // Configuration.
  input wire broadcast_segregate,
  input wire broadcast_rx_irq_en,
  input wire index_zero_irq_en,
  input wire access_irq_en,
  // Message processor side.
  input wire cmdValid,
  input wire [15:0] cmdWord,
  input wire cmdBroadcast,
  output wire cmdReady,
  input wire rxWordValid,
  input wire [DATA_W-1:0] rxWord,
  input wire txWordReq,
  output reg [DATA_W-1:0] txWord_q,
  output reg txWordValid_q,
  input wire msgDone,
  input wire msgError,
  input wire msgBusy,
  input wire msgIllegal,
  input wire [DATA_W-1:0] timeTag,
  // Shared RAM.
  output reg ramRd_q,
  output reg ramWr_q,
  output reg [ADDR_W-1:0] ramAddr_q,
  output reg [DATA_W-1:0] ramWdata_q,
  input wire [DATA_W-1:0] ramRdata,
  // Events.
  output reg broadcastIrq_q,
  output reg indexZeroIrq_q,
  output reg accessIrq_q,
  output reg wrapIrq_q
);

  // ==========================================================
  // States.
  localparam [8:0] S_IDLE = 9'h001;
  localparam [8:0] S_FETCH = 9'h002;
  localparam [8:0] S_XFER = 9'h004;
  localparam [8:0] S_TXRD = 9'h008;
  localparam [8:0] S_MIW = 9'h010;
  localparam [8:0] S_TAG = 9'h020;
  localparam [8:0] S_WB = 9'h040;
  localparam [8:0] S_IDX = 9'h080;
  localparam [8:0] S_END = 9'h100;

  reg [8:0] state_q;
  reg [1:0] fetchIdx_q;
  reg fetchLat_q;
  reg [10:0] cmdFields_q;
  reg isTx_q;
  reg isMode_q;
  reg broadcast_flag_q;
  reg [DATA_W-1:0] ctrl_q;
  reg [DATA_W-1:0] word2_q;
  reg [DATA_W-1:0] word3_q;
  reg [DATA_W-1:0] word4_q;
  reg [ADDR_W-1:0] dataPtr_q;
  reg [ADDR_W-1:0] recBase_q;
  reg good_q;
  reg [DATA_W-1:0] miw_q;
  reg [DATA_W-1:0] tag_q;
  reg txPend_q;

  wire [ADDR_W-1:0] descAddr;
  wire [ADDR_W-1:0] circNext;
  wire circWrap;
  wire modeBitsZero;
  wire circOne;
  wire [DATA_W-1:0] indexCount;
  wire [ADDR_W-1:0] descAddrCur;
  wire [ADDR_W-1:0] descAddrPtr;

  // ==========================================================
  // Mode decode.
  // Mode codes never see circular mode; they fall through to plain storage.
  assign modeBitsZero = ~ctrl_q[`RSBM_CW_PINGPONG_ENABLE] & ~ctrl_q[`RSBM_CW_CIR1] &
    ~ctrl_q[`RSBM_CW_CIR2];
  assign circOne = ~isMode_q & ~ctrl_q[`RSBM_CW_PINGPONG_ENABLE] & ~ctrl_q[`RSBM_CW_CIR2] &
    ctrl_q[`RSBM_CW_CIR1];
  assign indexCount = word3_q & `RSBM_MESSAGE_INDEX_COUNT_MASK;
  assign cmdReady = state_q[0];

  rsbm_desc_addr #(
    .ADDR_W(ADDR_W)
  ) uDesc (
    .cmdFields(cmdFields_q),
    .wordSel(fetchIdx_q),
    .descAddr(descAddr)
  );

  rsbm_ptr_next #(
    .ADDR_W(ADDR_W)
  ) uPtr (
    .lastPlusOne(dataPtr_q),
    .startPtr(word2_q[ADDR_W-1:0]),
    .endPtr(word4_q[ADDR_W-1:0]),
    .nextPtr(circNext),
    .wrapped(circWrap)
  );

  // ==========================================================
  // Sequencer.
  // The fetch reads one descriptor word every three cycles: issue, RAM answer,
  // capture. It is slower than a pipelined fetch, but the read strobe never
  // overlaps the capture of the word before it.
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= S_IDLE;
      fetchIdx_q <= 2'h0;
      fetchLat_q <= 1'b0;
      cmdFields_q <= 11'h000;
      isTx_q <= 1'b0;
      isMode_q <= 1'b0;
      broadcast_flag_q <= 1'b0;
      ctrl_q <= 16'h0000;
      word2_q <= 16'h0000;
      word3_q <= 16'h0000;
      word4_q <= 16'h0000;
      dataPtr_q <= 13'h0000;
      recBase_q <= 13'h0000;
      good_q <= 1'b0;
      miw_q <= 16'h0000;
      tag_q <= 16'h0000;
      txPend_q <= 1'b0;
      txWord_q <= 16'h0000;
      txWordValid_q <= 1'b0;
      ramRd_q <= 1'b0;
      ramWr_q <= 1'b0;
      ramAddr_q <= 13'h0000;
      ramWdata_q <= 16'h0000;
      broadcastIrq_q <= 1'b0;
      indexZeroIrq_q <= 1'b0;
      accessIrq_q <= 1'b0;
      wrapIrq_q <= 1'b0;
    end
    else
    begin
      ramRd_q <= 1'b0;
      ramWr_q <= 1'b0;
      txWordValid_q <= 1'b0;
      broadcastIrq_q <= 1'b0;
      indexZeroIrq_q <= 1'b0;
      accessIrq_q <= 1'b0;
      wrapIrq_q <= 1'b0;
      case (state_q)
        S_IDLE:
        begin
          // Only one command is in flight; the message processor waits on cmdReady.
          if (cmdValid)
          begin
            // T/R at bit 10, subaddress 9:5, count or mode code 4:0.
            cmdFields_q <= cmdWord[10:0];
            isTx_q <= cmdWord[10];
            isMode_q <= (cmdWord[9:5] == 5'h00) || (cmdWord[9:5] == 5'h1f);
            broadcast_flag_q <= cmdBroadcast;
            fetchIdx_q <= 2'h0;
            fetchLat_q <= 1'b0;
            state_q <= S_FETCH;
          end
        end
        S_FETCH:
        begin
          // One read issued, result captured two cycles after.
          if (!fetchLat_q)
          begin
            ramRd_q <= 1'b1;
            ramAddr_q <= descAddr;
            fetchLat_q <= 1'b1;
          end
          else if (!ramRd_q)
          begin
            case (fetchIdx_q)
              `RSBM_DESC_CTRL: ctrl_q <= ramRdata;
              `RSBM_DESC_PTR: word2_q <= ramRdata;
              `RSBM_DESC_CUR: word3_q <= ramRdata;
              default: word4_q <= ramRdata;
            endcase
            fetchLat_q <= 1'b0;
            fetchIdx_q <= fetchIdx_q + 2'h1;
            if (fetchIdx_q == `RSBM_DESC_END)
              state_q <= S_XFER;
          end
        end
        S_XFER:
        begin
          // Record base: current pointer in circular mode, data pointer A otherwise.
          // Records start with two header words, so data begins two words above.
          if (circOne)
            recBase_q <= word3_q[ADDR_W-1:0];
          else
            recBase_q <= word2_q[ADDR_W-1:0];
          if (circOne)
            dataPtr_q <= word3_q[ADDR_W-1:0] + `RSBM_REC_HDR;
          else
            dataPtr_q <= word2_q[ADDR_W-1:0] + `RSBM_REC_HDR;
          txPend_q <= 1'b0;
          state_q <= S_TXRD;
        end
        S_TXRD:
        begin
          // Data phase: writes for receive, reads for transmit.
          // A transmit read is refused while one is pending, so one word is in flight.
          if (txPend_q && !ramRd_q)
          begin
            txWord_q <= ramRdata;
            txWordValid_q <= 1'b1;
            txPend_q <= 1'b0;
          end
          if (!isTx_q && rxWordValid)
          begin
            ramWr_q <= 1'b1;
            ramAddr_q <= dataPtr_q;
            ramWdata_q <= rxWord;
            dataPtr_q <= dataPtr_q + 13'h0001;
          end
          else if (isTx_q && txWordReq && !txPend_q)
          begin
            ramRd_q <= 1'b1;
            ramAddr_q <= dataPtr_q;
            dataPtr_q <= dataPtr_q + 13'h0001;
            txPend_q <= 1'b1;
          end
          else if (msgDone && !txPend_q)
          begin
            // Completion waits for a pending transmit read so its word is not lost.
            good_q <= ~msgError & ~msgBusy & ~msgIllegal;
            miw_q <= {broadcast_flag_q, msgError, msgBusy, msgIllegal, 1'b0, cmdFields_q};
            tag_q <= timeTag;
            state_q <= S_MIW;
          end
        end
        S_MIW:
        begin
          // The information word is written even for bad messages; only the
          // pointer and index count updates that follow are withheld.
          ramWr_q <= 1'b1;
          ramAddr_q <= recBase_q;
          ramWdata_q <= miw_q;
          state_q <= S_TAG;
        end
        S_TAG:
        begin
          // Access and broadcast interrupt pulses come with the time tag, once the record is complete.
          ramWr_q <= 1'b1;
          ramAddr_q <= recBase_q + 13'h0001;
          ramWdata_q <= tag_q;
          accessIrq_q <= access_irq_en & ctrl_q[`RSBM_CW_IWA];
          broadcastIrq_q <= broadcast_flag_q & broadcast_rx_irq_en & ctrl_q[`RSBM_CW_IBR];
          state_q <= S_WB;
        end
        S_WB:
        begin
          // Post-processing: circular pointer or index count, only for clean messages.
          // A broadcast with segregation on would belong in its own buffer, which is
          // not built here, so in indexed mode it leaves the index and the pointer alone.
          state_q <= S_END;
          if (circOne && good_q)
          begin
            ramWr_q <= 1'b1;
            ramAddr_q <= descAddrCur;
            ramWdata_q <= {{(DATA_W-ADDR_W){1'b0}}, circNext};
            wrapIrq_q <= circWrap & index_zero_irq_en & ctrl_q[`RSBM_CW_INDEX_ZERO_IRQ];
          end
          else if (modeBitsZero && good_q && !(broadcast_flag_q && broadcast_segregate) &&
            (indexCount != 16'h0000))
          begin
            ramWr_q <= 1'b1;
            ramAddr_q <= descAddrCur;
            ramWdata_q <= (word3_q & ~`RSBM_MESSAGE_INDEX_COUNT_MASK) | (indexCount - 16'h0001);
            state_q <= S_IDX;
          end
        end
        S_IDX:
        begin
          // The decision uses the count as fetched, so a count of one means it has
          // just reached zero.
          state_q <= S_END;
          if (indexCount != 16'h0001)
          begin
            ramWr_q <= 1'b1;
            ramAddr_q <= descAddrPtr;
            ramWdata_q <= {{(DATA_W-ADDR_W){1'b0}}, dataPtr_q};
          end
          else
            indexZeroIrq_q <= index_zero_irq_en & ctrl_q[`RSBM_CW_INDEX_ZERO_IRQ];
        end
        // One idle cycle lets the last write settle before the next fetch.
        S_END:
          state_q <= S_IDLE;
        default:
          state_q <= S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Write-back addresses for the current and pointer descriptor words.
  // They reuse the latched command fields, so the addresses stay put even if
  // the message processor presents a new command word early.
  assign descAddrCur = `RSBM_DESC_BASE + {cmdFields_q, `RSBM_DESC_CUR};
  assign descAddrPtr = `RSBM_DESC_BASE + {cmdFields_q, `RSBM_DESC_PTR};

endmodule

/* tb/rsbm_ram_model.sv */
// Shared RAM partner model with a one-cycle read answer.
// Assumes the bench preloads descriptors and buffers through mem.
`timescale 1ns/100ps
module rsbm_ram_model (
  // Bus from the buffer manager.
  input wire sys_clk,
  input wire ramRd_q,
  input wire ramWr_q,
  input wire [12:0] ramAddr_q,
  input wire [15:0] ramWdata_q,
  // Read answer.
  output logic [15:0] ramRdata
);
  logic [15:0] mem [0:8191];
  initial ramRdata = 16'h0000;
  // ==========
  // Access
  // Outside the answer cycle the data toggles, so a late sample is caught.
  always @(posedge sys_clk)
  begin
    if (ramWr_q)
      mem[ramAddr_q] <= ramWdata_q;
    if (ramRd_q)
      ramRdata <= mem[ramAddr_q];
    else
      ramRdata <= ~ramRdata;
  end
endmodule

/* tb/rsbm_top_monitor.sv */
// Port checker for the buffer manager top.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/100ps
module rsbm_top_monitor (
  // Watched ports.
  input wire sys_clk,
  input wire rst_n,
  input wire broadcast_rx_irq_en,
  input wire index_zero_irq_en,
  input wire cmdValid,
  input wire [15:0] cmdWord,
  input wire cmdBroadcast,
  input wire cmdReady,
  input wire txWordReq,
  input wire txWordValid_q,
  input wire msgDone,
  input wire ramRd_q,
  input wire ramWr_q,
  input wire [12:0] ramAddr_q,
  input wire broadcastIrq_q,
  input wire indexZeroIrq_q,
  input wire wrapIrq_q
);
  logic [12:0] descQ;
  logic bcQ;
  wire taken = cmdValid && cmdReady;
  // ==========
  // Command capture
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      descQ <= 13'h0000;
      bcQ <= 1'b0;
    end
    else if (taken)
    begin
      descQ <= 13'h0400 + {cmdWord[10:0], 2'b00};
      bcQ <= cmdBroadcast;
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_rd(k);
    ramRd_q && ramAddr_q == descQ + k;
  endsequence
  // ==========
  // Properties
  a_desc_order: assert property (taken |-> ##[1:3] s_rd(13'h0) ##3 s_rd(13'h1)
    ##3 s_rd(13'h2) ##3 s_rd(13'h3)) else $error("descriptor fetch order");
  a_busy_fetch: assert property (taken |=> !cmdReady [*8])
    else $error("ready during fetch");
  a_done_write: assert property (msgDone |-> !cmdReady ##[1:12] ramWr_q)
    else $error("no record write");
  a_rd_pulse: assert property (ramRd_q |=> !ramRd_q)
    else $error("read strobe too long");
  a_end_static: assert property (ramWr_q |-> ramAddr_q != descQ + 13'h3)
    else $error("end pointer written");
  a_bc_irq: assert property (broadcastIrq_q |-> broadcast_rx_irq_en && bcQ)
    else $error("broadcast irq ungated");
  a_iz_irq: assert property (indexZeroIrq_q |-> index_zero_irq_en)
    else $error("index irq ungated");
  a_wrap_irq: assert property (wrapIrq_q |-> index_zero_irq_en)
    else $error("wrap irq ungated");
  a_tx_answer: assert property (txWordValid_q |-> $past(txWordReq, 3))
    else $error("tx word unrequested");
endmodule
bind rsbm_top rsbm_top_monitor i_mon (.sys_clk(sys_clk), .rst_n(rst_n),
  .broadcast_rx_irq_en(broadcast_rx_irq_en), .index_zero_irq_en(index_zero_irq_en),
  .cmdValid(cmdValid), .cmdWord(cmdWord), .cmdBroadcast(cmdBroadcast), .cmdReady(cmdReady),
  .txWordReq(txWordReq), .txWordValid_q(txWordValid_q), .msgDone(msgDone),
  .ramRd_q(ramRd_q), .ramWr_q(ramWr_q), .ramAddr_q(ramAddr_q),
  .broadcastIrq_q(broadcastIrq_q), .indexZeroIrq_q(indexZeroIrq_q), .wrapIrq_q(wrapIrq_q));

/* tb/rsbm_tb_top.sv */
// Self-checking bench: indexed and circular buffering through shared RAM.
// Assumes the RAM model holds descriptors loaded by the bench.
`timescale 1ns/100ps
module rsbm_tb_top;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic bcEn = 1'b1;
  logic cmdValid = 1'b0;
  logic cmdBroadcast = 1'b0;
  logic rxWordValid = 1'b0;
  logic txWordReq = 1'b0;
  logic msgDone = 1'b0;
  logic msgError = 1'b0;
  logic msgIll = 1'b0;
  logic [15:0] cmdWord = 16'h0000;
  logic [15:0] rxWord = 16'h0000;
  logic [15:0] timeTag = 16'h0000;
  wire cmdReady, txWordValid_q, ramRd_q, ramWr_q, bIrq, zIrq, aIrq, wIrq;
  wire [15:0] txWord_q, ramWdata_q, ramRdata;
  wire [12:0] ramAddr_q;
  integer bad_count = 0;
  integer n_tests = 0;
  integer zCnt = 0;
  integer bCnt = 0;
  integer aCnt = 0;
  integer wCnt = 0;
  integer k, j;
  rsbm_top i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .broadcast_segregate(1'b0),
    .broadcast_rx_irq_en(bcEn), .index_zero_irq_en(1'b1), .access_irq_en(1'b1),
    .cmdValid(cmdValid), .cmdWord(cmdWord), .cmdBroadcast(cmdBroadcast), .cmdReady(cmdReady),
    .rxWordValid(rxWordValid), .rxWord(rxWord), .txWordReq(txWordReq), .txWord_q(txWord_q),
    .txWordValid_q(txWordValid_q), .msgDone(msgDone), .msgError(msgError), .msgBusy(1'b0),
    .msgIllegal(msgIll), .timeTag(timeTag), .ramRd_q(ramRd_q), .ramWr_q(ramWr_q),
    .ramAddr_q(ramAddr_q), .ramWdata_q(ramWdata_q), .ramRdata(ramRdata),
    .broadcastIrq_q(bIrq), .indexZeroIrq_q(zIrq), .accessIrq_q(aIrq), .wrapIrq_q(wIrq));
  rsbm_ram_model i_ram (.sys_clk(sys_clk), .ramRd_q(ramRd_q), .ramWr_q(ramWr_q),
    .ramAddr_q(ramAddr_q), .ramWdata_q(ramWdata_q), .ramRdata(ramRdata));
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    if (zIrq)
      zCnt <= zCnt + 1;
    if (bIrq)
      bCnt <= bCnt + 1;
    if (aIrq)
      aCnt <= aCnt + 1;
    if (wIrq)
      wCnt <= wCnt + 1;
  end
  // ==========
  // Tasks
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      n_tests++;
      if (got !== exp)
      begin
        bad_count++;
        $display("Error at %0t: got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task mchk(input [12:0] a, input [15:0] exp);
    chk(i_ram.mem[a], exp);
  endtask
  task ld(input [15:0] c, input [15:0] w0, input [15:0] w1, input [15:0] w2);
    logic [12:0] a;
    begin
      a = 13'h0400 + {c[10:0], 2'b00};
      i_ram.mem[a] = w0;
      i_ram.mem[a + 13'h1] = w1;
      i_ram.mem[a + 13'h2] = w2;
      i_ram.mem[a + 13'h3] = 16'h0208;
    end
  endtask
  // Word count comes from the two low command bits; tag and data derive from d.
  task msg(input [15:0] c, input b, input e, input [15:0] d);
    begin
      cmdWord <= c;
      cmdBroadcast <= b;
      cmdValid <= 1'b1;
      timeTag <= d;
      @(posedge sys_clk);
      cmdValid <= 1'b0;
      // Four descriptor reads of three cycles each plus setup take thirteen cycles.
      repeat (13) @(posedge sys_clk);
      for (k = 0; k < c[1:0]; k++)
      begin
        txWordReq <= c[10];
        rxWordValid <= !c[10];
        rxWord <= d + k[15:0];
        @(posedge sys_clk);
        txWordReq <= 1'b0;
        rxWordValid <= 1'b0;
        for (j = 0; j < 5 && !(c[10] && txWordValid_q); j++)
          @(posedge sys_clk) #1;
        if (c[10])
          chk(txWord_q, d + k[15:0]);
        @(posedge sys_clk);
      end
      msgDone <= 1'b1;
      msgError <= e;
      @(posedge sys_clk);
      msgDone <= 1'b0;
      msgError <= 1'b0;
      for (j = 0; j < 60 && !cmdReady; j++)
        @(posedge sys_clk) #1;
      if (j == 60)
      begin
        bad_count++;
        end_sim;
      end
      @(posedge sys_clk);
    end
  endtask
  // ==========
  // Sequence
  initial
  begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    ld(16'h0822, 16'ha000, 16'h0100, 16'h0002);
    msg(16'h0822, 1'b0, 1'b0, 16'h1100);
    mchk(13'h0102, 16'h1100);
    mchk(13'h0100, 16'h0022);
    mchk(13'h0101, 16'h1100);
    mchk(13'h048a, 16'h0001);
    mchk(13'h0489, 16'h0104);
    msg(16'h0822, 1'b1, 1'b0, 16'h2200);
    mchk(13'h0104, 16'h8022);
    mchk(13'h0107, 16'h2201);
    mchk(13'h048a, 16'h0000);
    mchk(13'h0489, 16'h0104);
    chk(zCnt[15:0], 16'h0001);
    chk(bCnt[15:0], 16'h0001);
    bcEn <= 1'b0;
    msg(16'h0822, 1'b1, 1'b0, 16'h3300);
    mchk(13'h0106, 16'h3300);
    mchk(13'h048a, 16'h0000);
    chk(bCnt[15:0], 16'h0001);
    ld(16'h0823, 16'h4000, 16'h0120, 16'h0003);
    msgIll <= 1'b1;
    msg(16'h0823, 1'b0, 1'b0, 16'h8800);
    msgIll <= 1'b0;
    mchk(13'h0120, 16'h1023);
    mchk(13'h048e, 16'h0003);
    mchk(13'h048d, 16'h0120);
    chk(aCnt[15:0], 16'h0001);
    $display("indexed test done");
    ld(16'h0842, 16'h8002, 16'h0200, 16'h0200);
    msg(16'h0842, 1'b0, 1'b0, 16'h4400);
    mchk(13'h050a, 16'h0204);
    mchk(13'h0203, 16'h4401);
    msg(16'h0842, 1'b0, 1'b1, 16'h5500);
    mchk(13'h050a, 16'h0204);
    msg(16'h0842, 1'b0, 1'b0, 16'h6600);
    mchk(13'h0207, 16'h6601);
    mchk(13'h050a, 16'h0200);
    mchk(13'h0509, 16'h0200);
    mchk(13'h050b, 16'h0208);
    mchk(13'h0204, 16'h0042);
    chk(wCnt[15:0], 16'h0001);
    $display("circular receive test done");
    ld(16'h0c61, 16'h0002, 16'h0280, 16'h0280);
    i_ram.mem[13'h1587] = 16'h02a0;
    i_ram.mem[13'h0282] = 16'hbeef;
    msg(16'h0c61, 1'b0, 1'b0, 16'hbeef);
    mchk(13'h1586, 16'h0283);
    mchk(13'h0280, 16'h0461);
    $display("circular transmit test done");
    ld(16'h0802, 16'h0002, 16'h0300, 16'h0000);
    msg(16'h0802, 1'b0, 1'b0, 16'h7700);
    mchk(13'h0302, 16'h7700);
    mchk(13'h0409, 16'h0300);
    $display("mode code test done");
    end_sim;
  end
endmodule
